// ==== hw/instruction_decode_14bit.sv ====
// Decode and execute control for a 14-bit instruction word core
// How it works
// - Byte ops: top bits 00, four-bit code, destination bit, seven-bit address.
// - Add and subtract, register and literal, set carry, digit carry, zero.
// - Logic ops, complement, increment, decrement, move and clears touch only zero.
// - Rotates 1101/1100 shift through carry and change carry only.
// - Swap 1110 exchanges nibbles and leaves every flag alone.
// - Decrement/increment and skip skip on zero result, no flags, two cycles skipping.
// - Bit ops: top bits 01, two-bit code, bit index, address; 00 clears, 01 sets.
// - Bit tests skip on clear (10) or set (11), two cycles when skipping.
// - Changing the program counter or a true test costs a second no-op cycle.
// - Literal ops: top bits 11, eight-bit literal; exclusive or literal is 1010.
// - Return with literal loads work then returns; call, jump, returns take two cycles.
// - Standby and watchdog clear take one cycle and update timeout and powerdown.
// - Interrupt entry pushes only the return address, nothing else saved.
// - Read-modify-write of a port register takes the pin levels as operand.
// - Writing the timer zero counter clears its prescaler when assigned to it.
`timescale 1ns/100ps
module instruction_decode_14bit #(
  parameter int unsigned PC_W        = 13,
  parameter int unsigned STACK_DEPTH = 8,
  parameter logic [6:0]  TIMER0_ADDR = idec_pkg::TIMER0_ADDR_DEF
) (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  // Program memory
  output logic      [PC_W-1:0] pm_addr,
  input  wire logic [13:0]     pm_data,
  input  wire logic [1:0]      page_bits,
  // Data register file
  output logic      [6:0]      rf_addr,
  input  wire logic [7:0]      rf_rdata,
  input  wire logic [7:0]      rf_pin_data,
  input  wire logic            rf_is_port,
  output logic      [7:0]      rf_wdata,
  output logic                 rf_we,
  // Timer zero prescaler
  input  wire logic            prescaler_on_timer0,
  output logic                 prescaler_clear,
  // Interrupt, watchdog and standby
  input  wire logic            irq_req,
  output logic                 irq_ack,
  output logic                 irq_return,
  input  wire logic            wake_req,
  output logic                 sleep_enter,
  output logic                 watchdog_clear,
  // Core state
  output logic      [7:0]      work_reg,
  // Avalon-MM slave
  input  wire logic [3:0]      avs_address,
  input  wire logic            avs_read,
  input  wire logic            avs_write,
  input  wire logic [31:0]     avs_writedata,
  input  wire logic [3:0]      avs_byteenable,
  output logic      [31:0]     avs_readdata,
  output logic                 avs_waitrequest
);
  localparam int unsigned SP_W = $clog2(STACK_DEPTH);

  idec_pkg::core_state_e state_q, state_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [PC_W-1:0] stack_mem [STACK_DEPTH];
  logic [SP_W-1:0] sp_q;
  logic [7:0]      w_q;
  logic            c_q, dc_q, z_q, to_q, pd_q;
  logic            run_q;
  logic            rd_ack_q;
  logic [31:0]     rdata_q;

  wire [1:0] grp   = pm_data[idec_pkg::GRP_HI:idec_pkg::GRP_LO];
  wire [3:0] op4   = pm_data[idec_pkg::OP_HI:idec_pkg::OP_LO];
  wire       dbit  = pm_data[idec_pkg::DEST_BIT];
  wire [6:0] fadr  = pm_data[idec_pkg::FADR_HI:0];
  wire [7:0] k8    = pm_data[idec_pkg::K8_HI:0];
  wire [1:0] bop   = pm_data[idec_pkg::BOP_HI:idec_pkg::BOP_LO];
  wire [2:0] bidx  = pm_data[idec_pkg::BIDX_HI:idec_pkg::BIDX_LO];
  wire [10:0] k11  = pm_data[idec_pkg::K11_HI:0];
  wire        jump = pm_data[idec_pkg::JUMP_BIT];

  wire is_byte = (grp == idec_pkg::GRP_BYTE);
  wire is_bit  = (grp == idec_pkg::GRP_BIT);
  wire is_ctl  = (grp == idec_pkg::GRP_CTL);
  wire is_lit  = (grp == idec_pkg::GRP_LIT);

  wire is_misc  = is_byte & (op4 == idec_pkg::OP_MISC);
  wire misc_low = is_misc & ~dbit;
  wire movwf    = is_misc & dbit;
  wire op_ret   = misc_low & (k8 == idec_pkg::LOW_RETURN);
  wire op_rfie  = misc_low & (k8 == idec_pkg::LOW_RETURN_FROM_INTERRUPT);
  wire op_sleep = misc_low & (k8 == idec_pkg::LOW_SLEEP);
  wire op_wdt   = misc_low & (k8 == idec_pkg::LOW_WDTCLR);
  wire byte_op  = is_byte & ~is_misc;
  wire skip_op  = byte_op & ((op4 == idec_pkg::OP_DECS) | (op4 == idec_pkg::OP_INCS));
  wire lop_mov  = is_lit & (op4[3:2] == idec_pkg::LOP_MOVE);
  wire op_return_with_literal = is_lit & (op4[3:2] == idec_pkg::LOP_RET);
  wire lit_w    = is_lit & (op4 != idec_pkg::OP_LBAD);

  // Byte op decode; increment/decrement-skip reuse the plain adders
  function automatic idec_pkg::alu_op_e byte_sel(input logic [3:0] o);
    case (o)
      idec_pkg::OP_ADD:  byte_sel = idec_pkg::ALU_ADD;
      idec_pkg::OP_SUB:  byte_sel = idec_pkg::ALU_SUB;
      idec_pkg::OP_AND:  byte_sel = idec_pkg::ALU_AND;
      idec_pkg::OP_IOR:  byte_sel = idec_pkg::ALU_OR;
      idec_pkg::OP_XOR:  byte_sel = idec_pkg::ALU_XOR;
      idec_pkg::OP_COM:  byte_sel = idec_pkg::ALU_COM;
      idec_pkg::OP_INC,
      idec_pkg::OP_INCS: byte_sel = idec_pkg::ALU_INC;
      idec_pkg::OP_DEC,
      idec_pkg::OP_DECS: byte_sel = idec_pkg::ALU_DEC;
      idec_pkg::OP_CLR:  byte_sel = idec_pkg::ALU_CLR;
      idec_pkg::OP_RL:   byte_sel = idec_pkg::ALU_RLC;
      idec_pkg::OP_RR:   byte_sel = idec_pkg::ALU_RRC;
      idec_pkg::OP_SWAP: byte_sel = idec_pkg::ALU_SWAP;
      default:           byte_sel = idec_pkg::ALU_PASS;
    endcase
  endfunction : byte_sel

  function automatic idec_pkg::alu_op_e lit_sel(input logic [3:0] o);
    case (o)
      idec_pkg::OP_LIOR: lit_sel = idec_pkg::ALU_OR;
      idec_pkg::OP_LAND: lit_sel = idec_pkg::ALU_AND;
      idec_pkg::OP_LXOR: lit_sel = idec_pkg::ALU_XOR;
      default:
        if (o[3:2] == idec_pkg::LOP_SUB)
          lit_sel = o[idec_pkg::LSUB_ADD_BIT - idec_pkg::OP_LO] ? idec_pkg::ALU_ADD
                                                                  : idec_pkg::ALU_SUB;
        else
          lit_sel = idec_pkg::ALU_PASS;
    endcase
  endfunction : lit_sel

  idec_pkg::alu_op_e alu_op;
  logic [7:0]        alu_res;
  logic              alu_c, alu_dc, alu_z;

  wire rmw_port = rf_is_port & ((byte_op & dbit) | (is_bit & ~bop[1]));
  wire [7:0] operand = rmw_port ? rf_pin_data : rf_rdata;
  wire [7:0] alu_a   = is_lit ? k8 : operand;
  wire [7:0] bmask   = 8'h01 << bidx;
  wire       bit_val = |(operand & bmask);
  wire [7:0] bit_res = (bop == idec_pkg::BOP_SET) ? (operand | bmask) : (operand & ~bmask);

  assign alu_op = is_lit ? lit_sel(op4) : (movwf ? idec_pkg::ALU_PASW : byte_sel(op4));

  byte_alu u_alu (
    .op  (alu_op),
    .a   (alu_a),
    .w   (w_q),
    .cin (c_q),
    .res (alu_res),
    .c   (alu_c),
    .dc  (alu_dc),
    .z   (alu_z)
  );

  // An interrupt takes the slot of the fetched word, which is replayed later
  wire irq_take = (state_q == idec_pkg::ST_EXEC) & run_q & irq_req;
  wire exec_ok  = (state_q == idec_pkg::ST_EXEC) & run_q & ~irq_take;

  wire wr_reg   = exec_ok & ((byte_op & dbit) | movwf | (is_bit & ~bop[1]));
  wire wr_work  = exec_ok & ((byte_op & ~dbit) | lit_w);

  wire flag_ok  = exec_ok & ((byte_op & ~skip_op) | (lit_w & ~lop_mov & ~op_return_with_literal));
  wire z_en     = flag_ok & (alu_op != idec_pkg::ALU_SWAP) &
                  (alu_op != idec_pkg::ALU_RLC) & (alu_op != idec_pkg::ALU_RRC);
  wire arith    = (alu_op == idec_pkg::ALU_ADD) | (alu_op == idec_pkg::ALU_SUB);
  wire c_en     = flag_ok & (arith | (alu_op == idec_pkg::ALU_RLC) |
                  (alu_op == idec_pkg::ALU_RRC));
  wire dc_en    = flag_ok & arith;

  wire skip_z   = skip_op & alu_z;
  wire skip_b   = is_bit & (((bop == idec_pkg::BOP_TSTC) & ~bit_val) |
                  ((bop == idec_pkg::BOP_TSTS) & bit_val));
  wire skip_go  = exec_ok & (skip_z | skip_b);
  wire do_pop   = exec_ok & (op_ret | op_rfie | op_return_with_literal);
  wire do_call  = exec_ok & is_ctl & ~jump;
  wire branch   = exec_ok & (is_ctl | op_ret | op_rfie | op_return_with_literal);

  wire [SP_W-1:0] sp_top    = sp_q - {{(SP_W-1){1'b0}}, 1'b1};
  wire [PC_W-1:0] pc_inc    = pc_q + {{(PC_W-1){1'b0}}, 1'b1};
  wire [PC_W-1:0] ctl_tgt   = PC_W'({page_bits, k11});
  wire [PC_W-1:0] push_val  = irq_take ? pc_q : pc_inc;

  always_comb
  begin
    state_d = state_q;
    pc_d    = pc_q;
    case (state_q)
      idec_pkg::ST_EXEC:
        if (irq_take)
        begin
          pc_d    = PC_W'(idec_pkg::IRQ_VECTOR);
          state_d = idec_pkg::ST_HOLD;
        end
        else if (exec_ok)
        begin
          pc_d = pc_inc;
          if (is_ctl)
            pc_d = ctl_tgt;
          else if (do_pop)
            pc_d = stack_mem[sp_top];
          if (branch)
            state_d = idec_pkg::ST_HOLD;
          else if (skip_go)
            state_d = idec_pkg::ST_SKIP;
          else if (op_sleep)
            state_d = idec_pkg::ST_HALT;
        end
      idec_pkg::ST_SKIP:
      begin
        pc_d    = pc_inc;
        state_d = idec_pkg::ST_EXEC;
      end
      idec_pkg::ST_HOLD:
        state_d = idec_pkg::ST_EXEC;
      idec_pkg::ST_HALT:
        if (wake_req)
          state_d = idec_pkg::ST_EXEC;
      default:
        state_d = idec_pkg::ST_EXEC;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= idec_pkg::ST_EXEC;
      pc_q    <= PC_W'(idec_pkg::RESET_VECTOR);
      sp_q    <= '0;
    end
    else
    begin
      state_q <= state_d;
      pc_q    <= pc_d;
      if (irq_take | do_call)
        sp_q <= sp_q + {{(SP_W-1){1'b0}}, 1'b1};
      else if (do_pop)
        sp_q <= sp_top;
    end
  end

  // Stack contents need no reset; a pop before any push is a software fault
  always_ff @(posedge sys_clk)
  begin
    if (irq_take | do_call)
      stack_mem[sp_q] <= push_val;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      w_q  <= 8'h00;
      c_q  <= 1'b0;
      dc_q <= 1'b0;
      z_q  <= 1'b0;
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end
    else
    begin
      if (wr_work)
        w_q <= op_return_with_literal ? k8 : alu_res;
      if (c_en)
        c_q <= alu_c;
      if (dc_en)
        dc_q <= alu_dc;
      if (z_en)
        z_q <= alu_z;
      if (exec_ok & (op_sleep | op_wdt))
      begin
        to_q <= 1'b1;
        pd_q <= op_wdt;
      end
    end
  end

  assign pm_addr        = pc_q;
  assign rf_addr        = fadr;
  assign rf_we          = wr_reg;
  assign rf_wdata       = is_bit ? bit_res : alu_res;
  assign prescaler_clear = wr_reg & (fadr == TIMER0_ADDR) & prescaler_on_timer0;
  assign irq_ack        = irq_take;
  assign irq_return     = exec_ok & op_rfie;
  assign sleep_enter    = exec_ok & op_sleep;
  assign watchdog_clear = exec_ok & op_wdt;
  assign work_reg       = w_q;

  // Reads take one wait state so read data always comes from a flip-flop
  wire sel_ctrl = (avs_address == idec_pkg::REG_CTRL);
  wire sel_stat = (avs_address == idec_pkg::REG_STATUS);
  wire sel_work = (avs_address == idec_pkg::REG_WORK);
  wire sel_pc   = (avs_address == idec_pkg::REG_PC);
  wire [31:0] stat_word = {24'h000000, state_q, 1'b0, pd_q, to_q, z_q, dc_q, c_q};
  wire [31:0] rd_mux    = sel_ctrl ? {31'h00000000, run_q} :
                          sel_stat ? stat_word :
                          sel_work ? {24'h000000, w_q} :
                          sel_pc   ? 32'(pc_q) : 32'h00000000;

  assign avs_waitrequest = avs_read & ~rd_ack_q;
  assign avs_readdata    = rdata_q;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      run_q    <= idec_pkg::CTRL_RUN_RST;
      rd_ack_q <= 1'b0;
      rdata_q  <= 32'h00000000;
    end
    else
    begin
      rd_ack_q <= avs_read & ~rd_ack_q;
      if (avs_read & ~rd_ack_q)
        rdata_q <= rd_mux;
      if (avs_write & sel_ctrl & avs_byteenable[0])
        run_q <= avs_writedata[idec_pkg::CTRL_RUN_BIT];
    end
  end
endmodule : instruction_decode_14bit

// ==== hw/idec_pkg.sv ====
// Shared constants for the 14-bit instruction decoder
package idec_pkg;
  // Instruction field positions
  localparam int unsigned GRP_HI   = 13;
  localparam int unsigned GRP_LO   = 12;
  localparam int unsigned OP_HI    = 11;
  localparam int unsigned OP_LO    = 8;
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned FADR_HI  = 6;
  localparam int unsigned BOP_HI   = 11;
  localparam int unsigned BOP_LO   = 10;
  localparam int unsigned BIDX_HI  = 9;
  localparam int unsigned BIDX_LO  = 7;
  localparam int unsigned K8_HI    = 7;
  localparam int unsigned K11_HI   = 10;
  localparam int unsigned JUMP_BIT = 11;
  localparam int unsigned LOP_HI   = 11;
  localparam int unsigned LOP_LO   = 10;
  localparam int unsigned NIB_HI   = 7;
  localparam int unsigned NIB_LO   = 4;

  // Instruction groups
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT  = 2'h1;
  localparam logic [1:0] GRP_CTL  = 2'h2;
  localparam logic [1:0] GRP_LIT  = 2'h3;

  // Byte-oriented operation codes
  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_CLR  = 4'h1;
  localparam logic [3:0] OP_SUB  = 4'h2;
  localparam logic [3:0] OP_DEC  = 4'h3;
  localparam logic [3:0] OP_IOR  = 4'h4;
  localparam logic [3:0] OP_AND  = 4'h5;
  localparam logic [3:0] OP_XOR  = 4'h6;
  localparam logic [3:0] OP_ADD  = 4'h7;
  localparam logic [3:0] OP_MOV  = 4'h8;
  localparam logic [3:0] OP_COM  = 4'h9;
  localparam logic [3:0] OP_INC  = 4'hA;
  localparam logic [3:0] OP_DECS = 4'hB;
  localparam logic [3:0] OP_RR   = 4'hC;
  localparam logic [3:0] OP_RL   = 4'hD;
  localparam logic [3:0] OP_SWAP = 4'hE;
  localparam logic [3:0] OP_INCS = 4'hF;

  // Bit-oriented operation codes
  localparam logic [1:0] BOP_CLR  = 2'h0;
  localparam logic [1:0] BOP_SET  = 2'h1;
  localparam logic [1:0] BOP_TSTC = 2'h2;
  localparam logic [1:0] BOP_TSTS = 2'h3;

  // Literal operation codes (full and two-bit prefixes)
  localparam logic [1:0] LOP_MOVE = 2'h0;
  localparam logic [1:0] LOP_RET  = 2'h1;
  localparam logic [1:0] LOP_SUB  = 2'h3;
  localparam logic [3:0] OP_LIOR  = 4'h8;
  localparam logic [3:0] OP_LAND  = 4'h9;
  localparam logic [3:0] OP_LXOR  = 4'hA;
  localparam logic [3:0] OP_LBAD  = 4'hB;
  localparam int unsigned LSUB_ADD_BIT = 9;

  // Miscellaneous low bytes
  localparam logic [7:0] LOW_RETURN = 8'h08;
  localparam logic [7:0] LOW_RETURN_FROM_INTERRUPT = 8'h09;
  localparam logic [7:0] LOW_SLEEP  = 8'h63;
  localparam logic [7:0] LOW_WDTCLR = 8'h64;

  // Core defaults
  localparam logic [6:0]  TIMER0_ADDR_DEF = 7'h01;
  localparam logic [12:0] IRQ_VECTOR      = 13'h0004;
  localparam logic [12:0] RESET_VECTOR    = 13'h0000;

  // Bus registers, byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_WORK   = 4'h8;
  localparam logic [3:0] REG_PC     = 4'hC;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam logic        CTRL_RUN_RST = 1'b1;

  typedef enum logic [3:0] {
    ALU_ADD  = 4'h0,
    ALU_SUB  = 4'h1,
    ALU_AND  = 4'h2,
    ALU_OR   = 4'h3,
    ALU_XOR  = 4'h4,
    ALU_COM  = 4'h5,
    ALU_INC  = 4'h6,
    ALU_DEC  = 4'h7,
    ALU_PASS = 4'h8,
    ALU_CLR  = 4'h9,
    ALU_RLC  = 4'hA,
    ALU_RRC  = 4'hB,
    ALU_SWAP = 4'hC,
    ALU_PASW = 4'hD
  } alu_op_e;

  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_SKIP = 2'b01,
    ST_HOLD = 2'b10,
    ST_HALT = 2'b11
  } core_state_e;
endpackage : idec_pkg

// ==== hw/byte_alu.sv ====
// Eight-bit arithmetic and logic unit with carry and digit-carry
`timescale 1ns/100ps
module byte_alu (
  // Operation and operands
  input  wire idec_pkg::alu_op_e op,
  input  wire logic [7:0]        a,
  input  wire logic [7:0]        w,
  input  wire logic              cin,
  // Result and flags
  output logic      [7:0]        res,
  output logic                   c,
  output logic                   dc,
  output logic                   z
);
  // Subtract is a plus inverted w plus one, so carry means no borrow
  wire       is_sub = (op == idec_pkg::ALU_SUB);
  wire [7:0] b_eff  = is_sub ? ~w : w;
  wire [8:0] sum9   = {1'b0, a} + {1'b0, b_eff} + {8'h00, is_sub};
  wire [4:0] nib5   = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, is_sub};

  always_comb
  begin
    res = a;
    c   = cin;
    dc  = nib5[4];
    case (op)
      idec_pkg::ALU_ADD,
      idec_pkg::ALU_SUB:
      begin
        res = sum9[7:0];
        c   = sum9[8];
      end
      idec_pkg::ALU_AND:  res = a & w;
      idec_pkg::ALU_OR:   res = a | w;
      idec_pkg::ALU_XOR:  res = a ^ w;
      idec_pkg::ALU_COM:  res = ~a;
      idec_pkg::ALU_INC:  res = a + 8'h01;
      idec_pkg::ALU_DEC:  res = a - 8'h01;
      idec_pkg::ALU_CLR:  res = 8'h00;
      idec_pkg::ALU_PASW: res = w;
      idec_pkg::ALU_RLC:
      begin
        res = {a[6:0], cin};
        c   = a[7];
      end
      idec_pkg::ALU_RRC:
      begin
        res = {cin, a[7:1]};
        c   = a[0];
      end
      idec_pkg::ALU_SWAP: res = {a[3:0], a[7:4]};
      default:            res = a;
    endcase
  end

  assign z = (res == 8'h00);
endmodule : byte_alu

// ==== dv/idec_assertions.sv ====
// Port checks for the instruction decoder
`timescale 1ns/100ps
module idec_assertions #(
  parameter int unsigned PC_W        = 13,
  parameter logic [6:0]  TIMER0_ADDR = idec_pkg::TIMER0_ADDR_DEF
) (
  // Clock and reset
  input wire logic            sys_clk,
  input wire logic            rst_b,
  // Program memory
  input wire logic [PC_W-1:0] pm_addr,
  input wire logic [13:0]     pm_data,
  input wire logic [1:0]      page_bits,
  // Register file
  input wire logic [6:0]      rf_addr,
  input wire logic [7:0]      rf_rdata,
  input wire logic [7:0]      rf_pin_data,
  input wire logic            rf_is_port,
  input wire logic [7:0]      rf_wdata,
  input wire logic            rf_we,
  // Side strobes and state
  input wire logic            prescaler_on_timer0,
  input wire logic            prescaler_clear,
  input wire logic            irq_ack,
  input wire logic            sleep_enter,
  input wire logic            watchdog_clear,
  input wire logic [7:0]      work_reg
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  prescaler_clr_a : assert property (
    prescaler_clear == (rf_we && rf_addr == TIMER0_ADDR && prescaler_on_timer0))
    else $error("prescaler clear mismatch");
  irq_vector_a : assert property (
    irq_ack |=> pm_addr == PC_W'(idec_pkg::IRQ_VECTOR) ##1 $stable(pm_addr))
    else $error("interrupt vector wrong");
  irq_keep_w_a : assert property (
    irq_ack |=> $stable(work_reg)) else $error("work changed on interrupt");
  // A jump in the address is followed by one idle cycle
  branch_hold_a : assert property (
    (pm_addr != $past(pm_addr) + 1'b1 && pm_addr != $past(pm_addr)) |=> $stable(pm_addr))
    else $error("no idle cycle after branch");
  jump_target_a : assert property (
    (pm_addr != $past(pm_addr) + 1'b1 && pm_addr != $past(pm_addr)
     && $past(pm_data[13:12]) == 2'b10 && !$past(irq_ack))
    |-> pm_addr == {$past(page_bits), $past(pm_data[10:0])})
    else $error("branch target wrong");
  sleep_halt_a : assert property (
    sleep_enter |=> (pm_addr == $past(pm_addr) + 1'b1)
    ##1 ($stable(pm_addr) && !rf_we) [*3]) else $error("core ran in standby");
  standby_code_a : assert property (
    sleep_enter |-> pm_data == {6'h00, idec_pkg::LOW_SLEEP} && !rf_we)
    else $error("standby strobe wrong");
  watchdog_code_a : assert property (
    watchdog_clear |-> pm_data == {6'h00, idec_pkg::LOW_WDTCLR}
    ##1 pm_addr == $past(pm_addr) + 1'b1) else $error("watchdog strobe wrong");
  port_rmw_a : assert property (
    (rf_we && rf_is_port && pm_data[13:7] == 7'h11) |-> rf_wdata == rf_pin_data)
    else $error("port operand not from pins");
  dest_work_a : assert property (
    (rf_we && pm_data[13:12] == 2'b00) |-> pm_data[7]) else $error("write with d clear");
  bit_set_a : assert property (
    (rf_we && !rf_is_port && pm_data[13:10] == 4'h5)
    |-> rf_wdata == (rf_rdata | (8'h01 << pm_data[9:7]))) else $error("bit set wrong");
  swap_a : assert property (
    (rf_we && !rf_is_port && pm_data[13:8] == 6'h0E)
    |-> rf_wdata == {rf_rdata[3:0], rf_rdata[7:4]}) else $error("swap wrong");
endmodule : idec_assertions

bind instruction_decode_14bit idec_assertions #(
  .PC_W(PC_W), .TIMER0_ADDR(TIMER0_ADDR)) u_idec_assertions (
  .sys_clk, .rst_b, .pm_addr, .pm_data, .page_bits, .rf_addr, .rf_rdata, .rf_pin_data,
  .rf_is_port, .rf_wdata, .rf_we, .prescaler_on_timer0, .prescaler_clear, .irq_ack,
  .sleep_enter, .watchdog_clear, .work_reg);

// ==== dv/prog_mem_model.sv ====
// Program memory and register file facing the decoder
`timescale 1ns/100ps
module prog_mem_model #(
  parameter logic [6:0] PORT_ADDR = 7'h06
) (
  // Clock
  input  wire logic        sys_clk,
  // Program memory
  input  wire logic [12:0] pm_addr,
  output logic      [13:0] pm_data,
  // Register file
  input  wire logic [6:0]  rf_addr,
  output logic      [7:0]  rf_rdata,
  output logic      [7:0]  rf_pin_data,
  output logic             rf_is_port,
  input  wire logic [7:0]  rf_wdata,
  input  wire logic        rf_we
);
  logic [13:0] mem [0:63];
  logic [7:0]  rf  [0:127];

  assign pm_data    = mem[pm_addr[5:0]];
  assign rf_rdata   = rf[rf_addr];
  assign rf_is_port = rf_addr == PORT_ADDR;
  // Pins are driven against the latch, so a latch read cannot pass
  assign rf_pin_data = ~rf[rf_addr];

  always @(posedge sys_clk)
  begin
    if (rf_we)
      rf[rf_addr] <= rf_wdata;
  end
endmodule : prog_mem_model

// ==== dv/tb.sv ====
// Self-checking bench for the instruction decoder
`timescale 1ns/100ps
module tb;
  logic        sys_clk, rst_b, rf_is_port, rf_we, prescaler_on_timer0, prescaler_clear;
  logic        irq_req, irq_ack, irq_return, wake_req, sleep_enter, watchdog_clear;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [1:0]  page_bits;
  logic [3:0]  avs_address, avs_byteenable;
  logic [6:0]  rf_addr;
  logic [7:0]  rf_rdata, rf_pin_data, rf_wdata, work_reg;
  logic [12:0] pm_addr;
  logic [13:0] pm_data;
  logic [31:0] avs_writedata, avs_readdata, rdv, v;
  int          fail_count, n_checks, clr_cnt, n;

  instruction_decode_14bit u_instruction_decode_14bit (.sys_clk, .rst_b, .pm_addr, .pm_data,
    .page_bits, .rf_addr, .rf_rdata, .rf_pin_data, .rf_is_port, .rf_wdata, .rf_we,
    .prescaler_on_timer0, .prescaler_clear, .irq_req, .irq_ack, .irq_return, .wake_req,
    .sleep_enter, .watchdog_clear, .work_reg, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
  prog_mem_model u_prog_mem_model (.sys_clk, .pm_addr, .pm_data, .rf_addr, .rf_rdata,
    .rf_pin_data, .rf_is_port, .rf_wdata, .rf_we);

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Mid-cycle count avoids racing the combinational strobe
  always @(negedge sys_clk)
    if (prescaler_clear === 1'b1)
      clr_cnt++;

  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : chk
  task automatic bound(input int k);
    if (k >= 40)
    begin
      fail_count++;
      report_and_stop();
    end
  endtask : bound
  // Request holds until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    logic done;
    done = 1'b0;
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= !wr;
    for (n = 0; n < 40 && !done; n++)
    begin
      @(posedge sys_clk);
      done = !avs_waitrequest;
      rdv  = avs_readdata;
    end
    bound(done ? 0 : 40);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic ld(input int a, input logic [13:0] w);
    u_prog_mem_model.mem[a] = w;
  endtask : ld
  task automatic clr;
    for (int i = 0; i < 64; i++)
      u_prog_mem_model.mem[i] = 14'h0000;
  endtask : clr
  task automatic run_prog(input logic [12:0] stop);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (n = 0; n < 40 && pm_addr !== stop; n++)
      @(posedge sys_clk);
    bound(n);
    repeat (4) @(posedge sys_clk);
  endtask : run_prog
  task automatic expect_core(input logic [7:0] w, input logic [4:0] fl);
    bus(1'b0, idec_pkg::REG_WORK, 32'h0);
    chk("work", {24'h0, w}, rdv);
    chk("work port", {24'h0, w}, {24'h0, work_reg});
    bus(1'b0, idec_pkg::REG_STATUS, 32'h0);
    chk("flags", {27'h0, fl}, rdv & 32'h1F);
  endtask : expect_core

  task automatic t_regs;
    bus(1'b0, idec_pkg::REG_STATUS, 32'h0);
    chk("status", 32'h18, rdv);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, rdv);
    bus(1'b1, idec_pkg::REG_WORK, 32'hFF);
    bus(1'b0, idec_pkg::REG_WORK, 32'h0);
    chk("work", 32'h0, rdv);
    bus(1'b0, idec_pkg::REG_CTRL, 32'h0);
    chk("ctrl", 32'h1, rdv);
    bus(1'b1, idec_pkg::REG_CTRL, 32'h0);
    bus(1'b0, idec_pkg::REG_PC, 32'h0);
    v = rdv;
    bus(1'b0, idec_pkg::REG_PC, 32'h0);
    chk("pc held", v, rdv);
    bus(1'b1, idec_pkg::REG_CTRL, 32'h1);
    $display("test regs done");
  endtask : t_regs
  task automatic t_arith;
    clr(); ld(0, 14'h3C05); ld(1, 14'h00A0); ld(2, 14'h300F); ld(3, 14'h02A0); ld(4, 14'h3E01);
    ld(5, 14'h3A10); ld(6, 14'h2806);
    run_prog(13'h6);
    expect_core(8'h00, 5'h1E);
    chk("r20", 32'hF6, {24'h0, u_prog_mem_model.rf[32]});
    $display("test arith done");
  endtask : t_arith
  task automatic t_rot;
    clr(); ld(0, 14'h3089); ld(1, 14'h00A1); ld(2, 14'h0DA1); ld(3, 14'h0EA1); ld(4, 14'h0CA1);
    ld(5, 14'h2805);
    run_prog(13'h5);
    expect_core(8'h89, 5'h19);
    chk("r21", 32'h90, {24'h0, u_prog_mem_model.rf[33]});
    $display("test rotate done");
  endtask : t_rot
  task automatic t_skip;
    clr(); ld(0, 14'h3001); ld(1, 14'h00A2); ld(2, 14'h0BA2); ld(3, 14'h3055); ld(4, 14'h15A2);
    ld(5, 14'h1DA2); ld(6, 14'h3066); ld(7, 14'h1822); ld(8, 14'h3077); ld(9, 14'h2809);
    run_prog(13'h9);
    expect_core(8'h01, 5'h18);
    chk("r22", 32'h08, {24'h0, u_prog_mem_model.rf[34]});
    $display("test skip done");
  endtask : t_skip
  task automatic t_call;
    clr(); ld(0, 14'h2005); ld(1, 14'h2801); ld(5, 14'h2007); ld(6, 14'h345A); ld(7, 14'h0008);
    run_prog(13'h1);
    expect_core(8'h5A, 5'h18);
    $display("test call done");
  endtask : t_call
  task automatic t_sleep;
    clr(); ld(0, 14'h0064); ld(1, 14'h0063); ld(2, 14'h2802);
    run_prog(13'h2);
    bus(1'b0, idec_pkg::REG_STATUS, 32'h0);
    chk("standby", 32'hC8, rdv);
    wake_req <= 1'b1;
    @(posedge sys_clk);
    wake_req <= 1'b0;
    repeat (4) @(posedge sys_clk);
    bus(1'b0, idec_pkg::REG_STATUS, 32'h0);
    chk("woken", 32'h08, rdv & 32'hD8);
    $display("test standby done");
  endtask : t_sleep
  task automatic t_irq;
    clr(); ld(0, 14'h3033); ld(1, 14'h2801); ld(4, 14'h3AFF); ld(5, 14'h0009);
    run_prog(13'h1);
    irq_req <= 1'b1;
    for (n = 0; n < 40 && irq_ack !== 1'b1; n++)
      @(posedge sys_clk);
    bound(n);
    irq_req <= 1'b0;
    for (n = 0; n < 40 && irq_return !== 1'b1; n++)
      @(negedge sys_clk);
    bound(n);
    repeat (4) @(posedge sys_clk);
    expect_core(8'hCC, 5'h18);
    chk("back", 32'h1, {19'h0, pm_addr});
    $display("test interrupt done");
  endtask : t_irq
  task automatic t_port;
    clr(); ld(0, 14'h300F); ld(1, 14'h0086); ld(2, 14'h0886); ld(3, 14'h0181); ld(4, 14'h2804);
    prescaler_on_timer0 <= 1'b1;
    clr_cnt = 0;
    run_prog(13'h4);
    chk("port", 32'hF0, {24'h0, u_prog_mem_model.rf[6]});
    chk("pre clr", 32'h1, clr_cnt);
    $display("test port done");
  endtask : t_port

  initial
  begin
    rst_b = 1'b0; page_bits = 2'h0; prescaler_on_timer0 = 1'b0; irq_req = 1'b0;
    wake_req = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0;
    avs_writedata = 32'h0; avs_byteenable = 4'hF; fail_count = 0; n_checks = 0;
    clr();
    for (int i = 0; i < 128; i++)
      u_prog_mem_model.rf[i] = 8'h00;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_regs(); t_arith(); t_rot(); t_skip(); t_call(); t_sleep(); t_irq(); t_port();
    report_and_stop();
  end
endmodule : tb
